// ---- sim/tx_client_model.sv ----
// Client transmit source: sends frames of counting bytes on command.
// Assumes the block's byte stream handshake on the same clock.
`timescale 1ns/1ps
module tx_client_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command from the bench
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic cut,
  output logic busy,
  // Client stream
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_eop,
  output logic fifo_underflow
);
  logic [7:0] len_q;
  logic [7:0] idx_q;
  logic cut_q;
  logic [1:0] hold_q;

  // Bytes count from 1; idle data is the inverse of the last byte
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      busy <= 1'b0;
      len_q <= 8'h00;
      idx_q <= 8'h00;
      cut_q <= 1'b0;
      hold_q <= 2'h0;
      in_valid <= 1'b0;
      in_data <= 8'h00;
      in_eop <= 1'b0;
      fifo_underflow <= 1'b0;
    end
    else if (go)
    begin
      busy <= 1'b1;
      len_q <= len;
      cut_q <= cut;
      idx_q <= 8'h00;
      hold_q <= 2'h0;
      in_valid <= 1'b1;
      in_data <= 8'h01;
      in_eop <= (len == 8'h01);
    end
    else if (fifo_underflow)
    begin
      // Starvation held a few cycles so the cut is seen mid-frame
      hold_q <= hold_q + 2'h1;
      fifo_underflow <= (hold_q != 2'h2);
      busy <= (hold_q != 2'h2);
    end
    else if (in_valid && in_ready)
    begin
      idx_q <= idx_q + 8'h01;
      in_data <= in_data + 8'h01;
      in_eop <= (idx_q + 8'h02 == len_q);
      if (in_eop || (cut_q && idx_q == 8'h02))
      begin
        in_valid <= 1'b0;
        in_eop <= 1'b0;
        in_data <= ~in_data;
        busy <= ~in_eop;
        fifo_underflow <= ~in_eop;
      end
    end
endmodule

// ---- sim/tx_pad_crc_underflow_count_test.sv ----
// Bench for the transmit finishing stage: APB master, stalling sink.
// Assumes the client model file and the design package are compiled.
`timescale 1ns/1ps
module tx_pad_crc_underflow_count_test;
  import tx_fin_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic out_ready = 0, go = 0, cut = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  logic pready, pslverr, in_valid, in_ready, in_eop, fifo_underflow;
  logic out_valid, irq, busy, errv;
  logic [7:0] in_data, len = 8'h00;
  beat_t out_beat;
  beat_t rxq[$];
  int err_total = 0, total_checks = 0;
  int lens[5] = '{1, 10, 59, 60, 61};

  always #5 pclk = ~pclk;

  tx_pad_crc_underflow_count dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_eop(in_eop),
    .fifo_underflow(fifo_underflow), .out_valid(out_valid), .out_ready(out_ready),
    .out_beat(out_beat), .irq(irq));

  tx_client_model client_u (.pclk(pclk), .presetn(presetn), .go(go), .len(len),
    .cut(cut), .busy(busy), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .in_eop(in_eop), .fifo_underflow(fifo_underflow));

  // Sink stalls every other cycle so the output hold path is exercised
  always @(posedge pclk)
  begin
    out_ready <= presetn & ~out_ready;
    if (out_valid === 1'b1 && out_ready === 1'b1)
      rxq.push_back(out_beat);
  end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    check(pready === 1'b1, "no pready");
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rdv === exp && errv === 1'b0, "read value");
  endtask

  // Sends one frame and compares every beat with a reference built here
  task automatic frame(input logic [7:0] n, input logic c, input logic pad, input logic crc);
    logic [7:0] e[$];
    logic [31:0] f;
    int k;
    k = 0;
    rxq.delete();
    @(posedge pclk);
    len <= n;
    cut <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    while ((busy !== 1'b0 || rxq.size() == 0 || rxq[$].eop !== 1'b1) && k < 600)
    begin
      @(posedge pclk);
      k++;
    end
    check(k < 600, "frame timeout");
    for (int i = 0; i < (c ? 3 : n); i++)
      e.push_back(8'(i + 1));
    while (!c && pad && e.size() < MIN_FRAME)
      e.push_back(8'h00);
    f = 32'hFFFF_FFFF;
    foreach (e[i])
    begin
      f ^= {24'h0, e[i]};
      repeat (8) f = f[0] ? (f >> 1) ^ 32'hEDB8_8320 : f >> 1;
    end
    for (int i = 0; !c && crc && i < 4; i++)
      e.push_back(~f[8*i +: 8]);
    if (c)
      e.push_back(8'h00);
    check(rxq.size() == e.size(), "beat count");
    foreach (rxq[i])
      check(i < e.size() && rxq[i].data === e[i] && rxq[i].eop === (i == e.size() - 1)
        && rxq[i].err === (c && i == e.size() - 1), "beat content");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    #300us;
    err_total++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_PAD_CTL, 32'h0000_0001);
    rd(IDX_CRC_CTL, 32'h0000_0003);
    rd(IDX_UFL_LO, 32'h0000_0000);
    rd(IDX_UFL_HI, 32'h0000_0000);
    apb(1'b0, 14'h1234, 32'h0000_0000);
    check(errv === 1'b1 && rdv === 32'h0000_0000, "unmapped");
    apb(1'b1, IDX_PAD_CTL, 32'hFFFF_FFFF);
    rd(IDX_PAD_CTL, 32'h0000_0001);
    foreach (lens[i])
      frame(8'(lens[i]), 1'b0, 1'b1, 1'b1);
    frame(8'd70, 1'b0, 1'b1, 1'b1);
    // Padding goes off before CRC does and comes back after it
    apb(1'b1, IDX_PAD_CTL, 32'h0000_0000);
    frame(8'd60, 1'b0, 1'b0, 1'b1);
    frame(8'd100, 1'b0, 1'b0, 1'b1);
    apb(1'b1, IDX_CRC_CTL, 32'h0000_0001);
    frame(8'd64, 1'b0, 1'b0, 1'b0);
    frame(8'd65, 1'b0, 1'b0, 1'b0);
    apb(1'b1, IDX_CRC_CTL, 32'h0000_0003);
    apb(1'b1, IDX_PAD_CTL, 32'h0000_0001);
    apb(1'b1, IDX_IRQ_STS, 32'h0000_0007);
    frame(8'd20, 1'b1, 1'b1, 1'b1);
    @(posedge pclk);
    check(irq === 1'b0, "irq while masked");
    apb(1'b1, IDX_IRQ_MASK, 32'h0000_0002);
    @(posedge pclk);
    check(irq === 1'b1, "irq not raised");
    apb(1'b1, IDX_IRQ_STS, 32'h0000_0002);
    @(posedge pclk);
    check(irq === 1'b0, "irq not cleared");
    frame(8'd20, 1'b1, 1'b1, 1'b1);
    rd(IDX_UFL_LO, 32'h0000_0002);
    rd(IDX_UFL_LO, 32'h0000_0002);
    rd(IDX_UFL_HI, 32'h0000_0000);
    rd(IDX_UFL_LO, 32'h0000_0000);
    // Mid-run reset must bring the registers back to their reset values
    apb(1'b1, IDX_IRQ_MASK, 32'h0000_0003);
    apb(1'b1, IDX_PAD_CTL, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_IRQ_MASK, 32'h0000_0000);
    rd(IDX_PAD_CTL, 32'h0000_0001);
    check(irq === 1'b0, "irq after reset");
    complete_run();
  end
endmodule

// ---- verilog/crc32_byte.sv ----
// One byte step of the reflected Ethernet frame check sequence.
// Purely combinational; the caller holds the running value.
`timescale 1ns/1ps
module crc32_byte
  import tx_fin_pkg::*;
(
  // Running value and new byte
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  // Updated value
  output logic [31:0] crc_out
);

  // Eight bit-serial steps, least significant bit first
  always_comb
  begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++)
    begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    crc_out = c;
  end

endmodule

// ---- verilog/sat_counter.sv ----
// Saturating event counter with a clear that never loses an event.
// Assumes at most one increment per cycle.
`timescale 1ns/1ps
module sat_counter #(
  parameter int W = 36
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic inc,
  input wire logic clr,
  input wire logic clr_keep,
  // State
  output logic [W-1:0] count,
  output logic at_max
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  assign at_max = &count_q;
  assign count = count_q;

  // Clear reloads any event that raced it; otherwise hold at the top
  assign count_d = clr ? W'(clr_keep | inc) :
                   (inc && !at_max) ? count_q + W'(1) : count_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= '0;
    else if (ce)
      count_q <= count_d;
  end

endmodule

// ---- verilog/tx_fin_pkg.sv ----
// Shared constants and types of the transmit finishing stage.
// Assumes one clock domain and an APB register port with 32-bit data.
package tx_fin_pkg;

  // Register word indexes; byte address is four times the index
  localparam logic [13:0] IDX_PAD_CTL = 14'h1040;
  localparam logic [13:0] IDX_CRC_CTL = 14'h1080;
  localparam logic [13:0] IDX_UFL_LO = 14'h10C0;
  localparam logic [13:0] IDX_UFL_HI = 14'h10C1;
  localparam logic [13:0] IDX_IRQ_STS = 14'h1200;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h1201;
  localparam int ADDR_LSB = 2;

  // Reset values and field positions
  localparam logic [31:0] PAD_CTL_RST = 32'h0000_0001;
  localparam logic [31:0] CRC_CTL_RST = 32'h0000_0003;
  localparam logic [31:0] PAD_CTL_MASK = 32'h0000_0001;
  localparam logic [31:0] CRC_CTL_MASK = 32'h0000_0003;
  localparam int PAD_EN_BIT = 0;
  localparam int CRC_EN_BIT = 1;
  localparam int UFL_CNT_W = 36;
  localparam int UFL_HI_W = UFL_CNT_W - 32;

  // Interrupt status layout, shared by the mask register
  localparam int IRQ_W = 3;
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_TRUNC_BIT = 1;
  localparam int IRQ_SAT_BIT = 2;

  // Frame shape
  localparam int MIN_FRAME = 60;
  localparam int CRC_BYTES = 4;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY_REFL = 32'hEDB8_8320;

  // One byte beat on the outgoing stream
  typedef struct packed {
    logic [7:0] data;
    logic eop;
    logic err;
  } beat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_PAD, ST_CRC} fin_state_t;

endpackage

// ---- verilog/tx_pad_crc_underflow_count.sv ----
// Transmit finishing stage: pads short frames, appends the frame check
// sequence, counts frames cut short by a persistent FIFO underflow.
// Assumes a byte-wide client stream and an APB master on the same clock.
//
// What this block does
// - With padding on, frames under 60 bytes not cut by underflow get zero pad up to 60.
// - With padding off, frames pass with no pad bytes at all.
// - With CRC bit 1 set, compute and append CRC to every frame not cut by underflow.
// - With CRC bit 1 clear, send frames with no CRC appended.
// - Count each underflow-truncated frame in a 36-bit counter.
// - Lower counter word reads counter bits 31 to 0.
// - Upper word reads bits 35 to 32 in bits 3 to 0, rest zero.
// - Reading the upper word clears the whole counter.
// - Reading only the lower word leaves the counter untouched.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module tx_pad_crc_underflow_count
  import tx_fin_pkg::*;
#(
  parameter int MIN_FRAME_BYTES = MIN_FRAME,
  parameter int CNT_W = UFL_CNT_W
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Client transmit stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_eop,
  input wire logic fifo_underflow,
  // Outgoing stream
  output logic out_valid,
  input wire logic out_ready,
  output beat_t out_beat,
  // Interrupt
  output logic irq
);

  localparam int CW = $clog2(MIN_FRAME_BYTES + 1);

  // Refuse shapes the logic cannot serve
  generate
    if (CNT_W != UFL_CNT_W || MIN_FRAME_BYTES < 1 || MIN_FRAME_BYTES > 255)
    begin : g_bad
      $error("unsupported counter width or minimum frame length");
    end
  endgenerate

  fin_state_t state_q, state_d;
  logic [CW-1:0] cnt_q;
  logic [1:0] crc_idx_q;
  logic [31:0] crc_q;
  logic pad_f_q, crc_f_q;
  beat_t out_q;
  logic out_valid_q;
  logic [31:0] pad_ctl_q, crc_ctl_q, prdata_q;
  logic [IRQ_W-1:0] sts_q, mask_q;
  logic inc_setup_q;

  // Stream decode
  wire adv = ce & (~out_valid_q | out_ready);
  wire in_st = (state_q == ST_IDLE) | (state_q == ST_DATA);
  wire take = adv & in_st & in_valid;
  wire trunc = adv & (state_q == ST_DATA) & ~in_valid & fifo_underflow;
  wire pad_step = adv & (state_q == ST_PAD);
  wire crc_step = adv & (state_q == ST_CRC);
  wire emit = take | trunc | pad_step | crc_step;
  // Frame options are frozen at the first byte so a mid-frame write is harmless
  wire cur_pad = (state_q == ST_IDLE) ? pad_ctl_q[PAD_EN_BIT] : pad_f_q;
  wire cur_crc = (state_q == ST_IDLE) ? crc_ctl_q[CRC_EN_BIT] : crc_f_q;
  wire short_now = (32'(cnt_q) + 32'd1) < 32'(MIN_FRAME_BYTES);
  wire go_pad = take & in_eop & cur_pad & short_now;
  wire go_crc = take & in_eop & ~go_pad & cur_crc;
  wire pad_last = pad_step & ~short_now;
  wire [31:0] fcs = ~crc_q;
  wire [7:0] fcs_byte = fcs[8 * crc_idx_q +: 8];
  wire crc_last = crc_step & (crc_idx_q == 2'(CRC_BYTES - 1));

  assign in_ready = adv & in_st;

  // Byte and flags of the beat being produced
  wire [7:0] emit_data = take ? in_data : crc_step ? fcs_byte : PAD_BYTE;
  wire emit_eop = (take & in_eop & ~go_pad & ~cur_crc) | trunc |
                  (pad_last & ~crc_f_q) | crc_last;
  wire [31:0] crc_base = (state_q == ST_IDLE) ? CRC_INIT : crc_q;
  wire [31:0] crc_next;

  // Running CRC over data and pad bytes alike
  crc32_byte u_crc (
    .crc_in(crc_base),
    .data(emit_data),
    .crc_out(crc_next)
  );

  // Frame sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE, ST_DATA:
      begin
        if (trunc)
          state_d = ST_IDLE;
        else if (take)
          state_d = go_pad ? ST_PAD : go_crc ? ST_CRC : in_eop ? ST_IDLE : ST_DATA;
      end
      ST_PAD:
      begin
        if (pad_last)
          state_d = crc_f_q ? ST_CRC : ST_IDLE;
      end
      ST_CRC:
      begin
        if (crc_last)
          state_d = ST_IDLE;
      end
    endcase
  end

  // State, length and CRC registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      crc_idx_q <= '0;
      crc_q <= CRC_INIT;
      pad_f_q <= 1'b0;
      crc_f_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      if (state_d == ST_IDLE)
        cnt_q <= '0;
      else if ((take | pad_step) && short_now)
        cnt_q <= cnt_q + CW'(1);
      if (take && state_q == ST_IDLE)
      begin
        pad_f_q <= pad_ctl_q[PAD_EN_BIT];
        crc_f_q <= crc_ctl_q[CRC_EN_BIT];
      end
      if (take | pad_step)
        crc_q <= crc_next;
      crc_idx_q <= crc_step ? crc_idx_q + 2'd1 : (state_q == ST_CRC ? crc_idx_q : 2'd0);
    end
  end

  // Output beat register; holds while the sink stalls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end
    else if (adv)
    begin
      out_valid_q <= emit;
      if (emit)
        out_q <= '{data: emit_data, eop: emit_eop, err: trunc};
    end
  end

  assign out_valid = out_valid_q;
  assign out_beat = out_q;

  // APB decode; one access-phase cycle, read data captured in setup
  wire [13:0] idx = paddr[15:ADDR_LSB];
  wire sel_pad = idx == IDX_PAD_CTL;
  wire sel_crc = idx == IDX_CRC_CTL;
  wire sel_lo = idx == IDX_UFL_LO;
  wire sel_hi = idx == IDX_UFL_HI;
  wire sel_sts = idx == IDX_IRQ_STS;
  wire sel_msk = idx == IDX_IRQ_MASK;
  wire mapped = sel_pad | sel_crc | sel_lo | sel_hi | sel_sts | sel_msk;
  wire setup = ce & psel & ~penable;
  wire access = ce & psel & penable;
  wire wr = access & pwrite & mapped;
  wire rd_lo = access & ~pwrite & sel_lo;
  wire rd_hi = access & ~pwrite & sel_hi;

  assign pready = access;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_q;

  // Underflow counter
  wire [CNT_W-1:0] ufl_cnt;
  wire ufl_max;

  sat_counter #(.W(CNT_W)) u_ufl (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .inc(trunc),
    .clr(rd_hi),
    .clr_keep(inc_setup_q),
    .count(ufl_cnt),
    .at_max(ufl_max)
  );

  // Read mux; reserved bits read as zero
  wire [31:0] rd_val =
    sel_pad ? pad_ctl_q :
    sel_crc ? crc_ctl_q :
    sel_lo ? ufl_cnt[31:0] :
    sel_hi ? {{(32 - UFL_HI_W){1'b0}}, ufl_cnt[CNT_W-1:32]} :
    sel_sts ? {{(32 - IRQ_W){1'b0}}, sts_q} :
    sel_msk ? {{(32 - IRQ_W){1'b0}}, mask_q} : 32'h0000_0000;

  // Event sources for the status register
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_FRAME_BIT] = emit & emit_eop & ~trunc;
  assign ev[IRQ_TRUNC_BIT] = trunc;
  assign ev[IRQ_SAT_BIT] = trunc & ufl_max;
  wire [IRQ_W-1:0] w1c = (wr & sel_sts) ? pwdata[IRQ_W-1:0] : '0;

  // Registers; a truncation seen after the upper-word snapshot survives its clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_ctl_q <= PAD_CTL_RST;
      crc_ctl_q <= CRC_CTL_RST;
      prdata_q <= '0;
      sts_q <= '0;
      mask_q <= '0;
      inc_setup_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && sel_pad)
        pad_ctl_q <= pwdata & PAD_CTL_MASK;
      if (wr && sel_crc)
        crc_ctl_q <= pwdata & CRC_CTL_MASK;
      if (wr && sel_msk)
        mask_q <= pwdata[IRQ_W-1:0];
      if (setup)
        prdata_q <= rd_val;
      inc_setup_q <= setup & sel_hi & ~pwrite & trunc;
      sts_q <= (sts_q & ~w1c) | ev; // Set wins over clear
    end
  end

  assign irq = |(sts_q & mask_q);

  // Helper: bytes emitted in the current outgoing frame
  logic [15:0] em_len_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      em_len_q <= '0;
    else if (emit)
      em_len_q <= emit_eop ? 16'h0000 : em_len_q + 16'h0001;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Padded frames reach the minimum, plus four with CRC on
  pad_len_a: assert property (emit && emit_eop && !trunc && cur_pad |->
    32'(em_len_q) + 32'd1 >= 32'(MIN_FRAME_BYTES) + (cur_crc ? CRC_BYTES : 0))
    else $error("padded frame shorter than minimum");
  no_pad_a: assert property (state_q == ST_PAD |-> pad_f_q)
    else $error("pad bytes sent with padding off");
  crc_on_a: assert property (go_crc |=> state_q == ST_CRC [*4] ##1
    (state_q == ST_CRC || state_q == ST_IDLE || !ce))
    else $error("CRC bytes not appended");
  crc_off_a: assert property (state_q == ST_CRC |-> crc_f_q)
    else $error("CRC appended with insertion off");
  cnt_inc_a: assert property (trunc && !rd_hi && !ufl_max |=>
    ufl_cnt == $past(ufl_cnt) + CNT_W'(1))
    else $error("truncated frame not counted");
  rd_low_a: assert property (setup && sel_lo && !pwrite |=>
    prdata == $past(ufl_cnt[31:0]))
    else $error("lower counter word wrong");
  rd_high_a: assert property (setup && sel_hi && !pwrite |=>
    prdata[31:UFL_HI_W] == '0 && prdata[UFL_HI_W-1:0] == $past(ufl_cnt[CNT_W-1:32]))
    else $error("upper counter word wrong");
  hi_clear_a: assert property (rd_hi && !trunc && !inc_setup_q |=> ufl_cnt == '0)
    else $error("upper word read did not clear");
  lo_keep_a: assert property (rd_lo && !trunc |=> $stable(ufl_cnt))
    else $error("lower word read changed counter");
  pad_first_a: assert property (pad_last && crc_f_q |=> state_q == ST_CRC)
    else $error("CRC not after last pad byte");
  sat_hold_a: assert property (ufl_max && trunc && !rd_hi |=> ufl_max)
    else $error("underflow counter wrapped");

  // Guards that apply on every cycle, not only the saturated corner
  // Counter only climbs between clears; a wrap would show as a drop
  no_wrap_a: assert property (!rd_hi |=> ufl_cnt >= $past(ufl_cnt))
    else $error("underflow counter went backwards");
  // A truncation racing the upper-word snapshot survives the clear as one
  hi_race_a: assert property (rd_hi && inc_setup_q |=> ufl_cnt == CNT_W'(1))
    else $error("racing truncation lost by clear");
  // Pad bytes are zero and the cut beat closes the frame flagged
  pad_byte_a: assert property (pad_step |-> emit_data == PAD_BYTE)
    else $error("pad byte not zero");
  trunc_beat_a: assert property (trunc |=> out_valid && out_beat.eop && out_beat.err &&
    out_beat.data == PAD_BYTE && state_q == ST_IDLE)
    else $error("truncation terminator missing");
  // A stalled beat must not change, or a byte would be lost downstream
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("outgoing beat changed while stalled");
  // Options are latched once per frame so a mid-frame write cannot split it
  opt_hold_a: assert property (state_q != ST_IDLE |=> $stable(pad_f_q) && $stable(crc_f_q))
    else $error("frame options changed mid-frame");
  // Status keeps the event even when a clear lands in the same cycle
  sts_set_a: assert property (trunc |=> sts_q[IRQ_TRUNC_BIT])
    else $error("truncation status not set");
  // Control words land masked and read back through the setup capture
  pad_wr_a: assert property (wr && sel_pad |=> pad_ctl_q == ($past(pwdata) & PAD_CTL_MASK))
    else $error("padding control write lost");
  ctl_rd_a: assert property (setup && sel_crc && !pwrite |=> prdata == $past(crc_ctl_q))
    else $error("CRC control read wrong");

  // Main scenarios
  pad_frame_c: cover property (go_pad ##[1:60] pad_last);
  crc_frame_c: cover property (crc_last);
  trunc_frame_c: cover property (trunc);
  hi_clear_c: cover property (rd_hi && ufl_cnt != '0);
  irq_rise_c: cover property ($rose(irq));

endmodule
